// >>> jlr_pkg.sv
// Package for the compact register jump-and-link decode/execute block.
// Assumes a 32-bit core with 5-bit register specifiers.
package jlr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction fields
  localparam int unsigned          MAJOR_LSB      = 26;
  localparam int unsigned          LINK_LSB       = 21;
  localparam int unsigned          TARGET_LSB     = 16;
  localparam int unsigned          MINOR_LSB      = 6;
  localparam logic [5:0]           MAJOR_GROUP    = 6'h00;
  localparam logic [9:0]           MINOR_PLAIN    = 10'h03c;
  localparam logic [9:0]           MINOR_BARRIER  = 10'h07c;
  localparam logic [5:0]           SUBGROUP_CODE  = 6'h3c;
  localparam logic [4:0]           DEFAULT_LINK   = 5'h1f;
  localparam logic [4:0]           ZERO_REG       = 5'h00;
  localparam logic [31:0]          LINK_INCREMENT = 32'h0000_0004;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [31:0]          RESET_PC       = 32'h0000_0000;
  localparam logic                 RESET_MODE     = 1'b1;

  typedef enum logic [1:0] {
    JLR_IDLE    = 2'b00,
    JLR_SQUASH  = 2'b01,
    JLR_BARRIER = 2'b10
  } jlr_state_t;

endpackage : jlr_pkg

// >>> jlr_core.sv
// Decode and execute of the compact register jump-and-link and its barrier form.
// Assumes a register file outside with one read port (combinational) and one
// write port; the fetch unit takes redirect and the fault flag with the target.

////////////////////////////////////////////////////////////////////////////
// Function
// - Decode plain and barrier forms by major, minor and subgroup codes.
// - Link register gets current instruction address plus four.
// - Assembler default link field is 31; hardware writes whatever nonzero field says.
// - Without base set, target bit 0 zero means address error at fetch.
// - With base set, mode bit loads from target bit 0, pc bit 0 cleared.
// - Mode 0 and unaligned target faults at target fetch, not at jump.
// - No delay slot; the next sequential instruction is squashed.
// - Any instruction, even a jump, may follow; never flagged illegal.
// - Barrier form clears all hazards before the target is fetched.
// - Barrier form runs in every mode, no coprocessor-unusable check.
// - Register jump forms are link field zero; link write is dropped.
module jlr_core #(
  parameter bit HAS_BASE_SET = 1'b1
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // Decode input
  input  wire logic        instr_valid,
  input  wire logic [31:0] instr_word,
  input  wire logic [31:0] instr_addr,
  // Register file read
  output logic      [4:0]  target_reg_field,
  input  wire logic [31:0] target_value,
  // Register file write
  output logic             link_we,
  output logic      [4:0]  link_reg_field,
  output logic      [31:0] link_data,
  // Fetch redirect
  output logic             redirect,
  output logic      [31:0] redirect_pc,
  output logic             instr_set_select_bit,
  output logic             target_fetch_fault,
  output logic             squash_next,
  // Hazard control
  output logic             hazard_clear_req,
  input  wire logic        hazard_clear_done,
  output logic             stall,
  output logic             is_jump,
  output logic             is_barrier
);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  // Matches one minor code inside the shared major group and subgroup
  function automatic logic hit_code(
    input logic [31:0] word,
    input logic [9:0]  code
  );
    logic [5:0] major;
    logic [9:0] minor;
    logic [5:0] subgroup;
    major    = word[jlr_pkg::MAJOR_LSB +: 6];
    minor    = word[jlr_pkg::MINOR_LSB +: 10];
    subgroup = word[5:0];
    return major == jlr_pkg::MAJOR_GROUP
           && subgroup == jlr_pkg::SUBGROUP_CODE
           && minor == code;
  endfunction : hit_code

  logic       hit_plain;
  logic       hit_barrier;
  logic [4:0] link_field;

  // No mode or coprocessor qualifier: the barrier form is legal everywhere
  always_comb begin
    hit_plain   = instr_valid && hit_code(instr_word, jlr_pkg::MINOR_PLAIN);
    hit_barrier = instr_valid && hit_code(instr_word, jlr_pkg::MINOR_BARRIER);
    link_field  = instr_word[jlr_pkg::LINK_LSB +: 5];
  end

  assign target_reg_field = instr_word[jlr_pkg::TARGET_LSB +: 5];
  assign is_jump          = hit_plain || hit_barrier;
  assign is_barrier       = hit_barrier;

  ////////////////////////////////////////////////////////////////////////////
  // Target
  logic [31:0] tgt_pc;
  logic        tgt_mode;
  logic        tgt_fault;

  // Read port sampled in the decode cycle, before the link write lands
  always_comb begin
    tgt_pc = {target_value[31:1], 1'b0};
    if (HAS_BASE_SET) begin
      tgt_mode  = target_value[0];
      tgt_fault = !target_value[0] && target_value[1];
    end else begin
      // Only the compact set exists, so bit 0 low names an unusable mode
      tgt_mode  = 1'b1;
      tgt_fault = !target_value[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control
  jlr_pkg::jlr_state_t state;
  jlr_pkg::jlr_state_t next_state;
  logic                take_jump;
  logic                take_barrier;
  logic                release_barrier;

  always_comb begin
    // Taken only from idle; the squash cycle swallows the sequential slot
    take_jump       = is_jump && state == jlr_pkg::JLR_IDLE;
    take_barrier    = take_jump && hit_barrier;
    release_barrier = state == jlr_pkg::JLR_BARRIER && hazard_clear_done;
  end

  always_comb begin
    next_state = state;
    unique case (state)
      jlr_pkg::JLR_IDLE: begin
        if (take_barrier) begin
          next_state = jlr_pkg::JLR_BARRIER;
        end else if (take_jump) begin
          next_state = jlr_pkg::JLR_SQUASH;
        end
      end
      jlr_pkg::JLR_SQUASH: begin
        // Whatever sits in the slot is dropped quietly, never flagged illegal
        next_state = jlr_pkg::JLR_IDLE;
      end
      jlr_pkg::JLR_BARRIER: begin
        if (release_barrier) begin
          next_state = jlr_pkg::JLR_SQUASH;
        end
      end
      default: begin
        next_state = jlr_pkg::JLR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state <= jlr_pkg::JLR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link write
  logic        next_link_we;
  logic [4:0]  next_link_reg_field;
  logic [31:0] next_link_data;

  always_comb begin
    next_link_we        = 1'b0;
    next_link_reg_field = link_reg_field;
    next_link_data      = link_data;
    if (take_jump) begin
      next_link_reg_field = link_field;
      next_link_data      = instr_addr + jlr_pkg::LINK_INCREMENT;
      // Field zero discards the link, giving the register jump forms
      next_link_we        = link_field != jlr_pkg::ZERO_REG;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      link_we        <= 1'b0;
      link_reg_field <= jlr_pkg::ZERO_REG;
      link_data      <= jlr_pkg::RESET_PC;
    end else begin
      link_we        <= next_link_we;
      link_reg_field <= next_link_reg_field;
      link_data      <= next_link_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Held barrier target
  logic [31:0] held_pc;
  logic [31:0] next_held_pc;
  logic        held_mode;
  logic        next_held_mode;
  logic        held_fault;
  logic        next_held_fault;

  // Kept from decode, as the register may be rewritten while hazards clear
  always_comb begin
    next_held_pc    = held_pc;
    next_held_mode  = held_mode;
    next_held_fault = held_fault;
    if (take_barrier) begin
      next_held_pc    = tgt_pc;
      next_held_mode  = tgt_mode;
      next_held_fault = tgt_fault;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      held_pc    <= jlr_pkg::RESET_PC;
      held_mode  <= jlr_pkg::RESET_MODE;
      held_fault <= 1'b0;
    end else begin
      held_pc    <= next_held_pc;
      held_mode  <= next_held_mode;
      held_fault <= next_held_fault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fetch redirect
  logic        next_redirect;
  logic [31:0] next_redirect_pc;
  logic        next_mode;
  logic        next_fault;
  logic        next_squash;

  always_comb begin
    next_redirect    = 1'b0;
    next_redirect_pc = redirect_pc;
    next_mode        = instr_set_select_bit;
    next_fault       = 1'b0;
    next_squash      = 1'b0;
    if (take_jump && !take_barrier) begin
      next_redirect    = 1'b1;
      next_redirect_pc = tgt_pc;
      next_mode        = tgt_mode;
      next_fault       = tgt_fault;
      next_squash      = 1'b1;
    end else if (release_barrier) begin
      // Redirect held back until hazards are gone, so the target sees new state
      next_redirect    = 1'b1;
      next_redirect_pc = held_pc;
      next_mode        = held_mode;
      next_fault       = held_fault;
      next_squash      = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      redirect             <= 1'b0;
      redirect_pc          <= jlr_pkg::RESET_PC;
      instr_set_select_bit <= jlr_pkg::RESET_MODE;
      target_fetch_fault   <= 1'b0;
      squash_next          <= 1'b0;
    end else begin
      redirect             <= next_redirect;
      redirect_pc          <= next_redirect_pc;
      instr_set_select_bit <= next_mode;
      target_fetch_fault   <= next_fault;
      squash_next          <= next_squash;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hazard control
  assign hazard_clear_req = state == jlr_pkg::JLR_BARRIER;
  // Decode holds for the whole wait; cheaper than a skid slot for one rare form
  assign stall            = state == jlr_pkg::JLR_BARRIER;

endmodule : jlr_core

// >>> jlr_core_chk.sv
// Port assertions for the register jump-and-link block.
// Assumes it is bound to every jlr_core instance.
module jlr_core_chk #(
  parameter bit HAS_BASE_SET = 1'b1
) (
  // Clock, reset, decode side
  input wire logic        core_clk, rst_b, instr_valid, hazard_clear_done,
  input wire logic [31:0] instr_word, instr_addr, target_value,
  // Results
  input wire logic        link_we, redirect, instr_set_select_bit, target_fetch_fault,
  input wire logic        squash_next, hazard_clear_req, stall, is_barrier, is_jump,
  input wire logic [31:0] link_data, redirect_pc,
  input wire logic [4:0]  target_reg_field, link_reg_field
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic grp, pl, br, take;
  // Own decode, so a wrong decode in the block cannot hide a wrong take
  assign grp  = instr_word[31:26] == jlr_pkg::MAJOR_GROUP && instr_word[5:0] == jlr_pkg::SUBGROUP_CODE;
  assign pl   = grp && instr_word[15:6] == jlr_pkg::MINOR_PLAIN;
  assign br   = grp && instr_word[15:6] == jlr_pkg::MINOR_BARRIER;
  assign take = instr_valid && (pl || br) && !stall && !redirect;

  AST_DECODE: assert property (is_barrier == (instr_valid && br)
    && target_reg_field == instr_word[20:16]) else $error("decode mismatch");
  AST_JUMP: assert property (is_jump == (instr_valid && (pl || br)))
    else $error("jump decode mismatch");
  AST_LINK: assert property (take |=> link_data == $past(instr_addr) + 32'h0000_0004
    && link_reg_field == $past(instr_word[25:21])) else $error("link value wrong");
  AST_LINK_WE: assert property (take |=> link_we == ($past(instr_word[25:21]) != 5'h00))
    else $error("link write enable wrong");
  AST_PLAIN: assert property (take && pl |=> redirect && squash_next
    && redirect_pc == {$past(target_value[31:1]), 1'b0}) else $error("plain jump wrong");
  AST_MODE: assert property (take && pl |=> instr_set_select_bit ==
    (HAS_BASE_SET ? $past(target_value[0]) : 1'b1)) else $error("mode bit wrong");
  AST_FAULT: assert property (take && pl |=> target_fetch_fault == (!$past(target_value[0])
    && (!HAS_BASE_SET || $past(target_value[1])))) else $error("fault flag wrong");
  AST_BAR_HOLD: assert property (take && br |=> stall && hazard_clear_req && !redirect)
    else $error("barrier did not wait");
  AST_BAR_GO: assert property (hazard_clear_req && hazard_clear_done |=>
    redirect && squash_next && !hazard_clear_req) else $error("barrier release wrong");
  AST_SLOT: assert property (redirect |=> !redirect && !link_we)
    else $error("squashed slot executed");
endmodule : jlr_core_chk

bind jlr_core jlr_core_chk #(.HAS_BASE_SET(HAS_BASE_SET)) u_jlr_core_chk (.*);

// >>> tb_jlr_core.sv
// Directed testbench for the register jump-and-link block.
// Assumes the block alone; inputs change 1 ns after each rising edge.
module tb_jlr_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, rst_b, instr_valid, hazard_clear_done, link_we, redirect;
  logic        instr_set_select_bit, target_fetch_fault, squash_next;
  logic        hazard_clear_req, stall, is_jump, is_barrier;
  logic [31:0] instr_word, instr_addr, target_value, link_data, redirect_pc;
  logic [4:0]  target_reg_field, link_reg_field;
  int          errors = 0;
  int          compares = 0;

  jlr_core u_jlr_core (
    .core_clk             (core_clk),
    .rst_b                (rst_b),
    .instr_valid          (instr_valid),
    .instr_word           (instr_word),
    .instr_addr           (instr_addr),
    .target_reg_field     (target_reg_field),
    .target_value         (target_value),
    .link_we              (link_we),
    .link_reg_field       (link_reg_field),
    .link_data            (link_data),
    .redirect             (redirect),
    .redirect_pc          (redirect_pc),
    .instr_set_select_bit (instr_set_select_bit),
    .target_fetch_fault   (target_fetch_fault),
    .squash_next          (squash_next),
    .hazard_clear_req     (hazard_clear_req),
    .hazard_clear_done    (hazard_clear_done),
    .stall                (stall),
    .is_jump              (is_jump),
    .is_barrier           (is_barrier)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // Wide enough for the largest packed group of outputs compared at once
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic [31:0] enc(input logic bar, input logic [4:0] lk, input logic [4:0] tg);
    return {jlr_pkg::MAJOR_GROUP, lk, tg, bar ? jlr_pkg::MINOR_BARRIER : jlr_pkg::MINOR_PLAIN,
            jlr_pkg::SUBGROUP_CODE};
  endfunction : enc

  // Returns 1 ns after the taking edge, where the result pulses stand
  task automatic issue(input logic [31:0] w, input logic [31:0] a, input logic [31:0] tv,
                       input logic hold);
    @(posedge core_clk);
    #1;
    instr_valid  = 1'b1;
    instr_word   = w;
    instr_addr   = a;
    target_value = tv;
    @(posedge core_clk);
    #1;
    instr_valid = hold;
  endtask : issue

  task automatic t_plain();
    issue(enc(1'b0, 5'h05, 5'h09), 32'h0000_0100, 32'h1000_0001, 1'b0);
    chk(target_reg_field, 32'h0000_0009);
    chk({link_we, link_reg_field, link_data}, {1'b1, 5'h05, 32'h0000_0104});
    chk({redirect, squash_next, redirect_pc}, {2'h3, 32'h1000_0000});
    chk({instr_set_select_bit, target_fetch_fault}, 32'h0000_0002);
  endtask : t_plain

  task automatic t_fault();
    issue(enc(1'b0, jlr_pkg::DEFAULT_LINK, 5'h02), 32'h0000_0200, 32'h0000_2002, 1'b1);
    chk(link_reg_field, 32'h0000_001f);
    chk({is_jump, is_barrier}, 32'h0000_0002);
    chk({instr_set_select_bit, target_fetch_fault, redirect_pc}, {2'h1, 32'h0000_2002});
    // A jump in the squashed slot must be dropped, then taken once decode is free
    instr_word   = enc(1'b0, 5'h01, 5'h03);
    instr_addr   = 32'h0000_0204;
    target_value = 32'h0000_3000;
    @(posedge core_clk);
    #1;
    chk(redirect, 32'h0000_0000);
    @(posedge core_clk);
    #1;
    instr_valid = 1'b0;
    chk({redirect, target_fetch_fault, instr_set_select_bit}, 32'h0000_0004);
    chk(link_data, 32'h0000_0208);
  endtask : t_fault

  task automatic t_regjump();
    issue(enc(1'b0, 5'h00, 5'h04), 32'h0000_0300, 32'h0000_4001, 1'b0);
    chk({link_we, redirect}, 32'h0000_0001);
    issue(enc(1'b0, 5'h07, 5'h07), 32'h0000_0304, 32'h0000_5001, 1'b0);
    chk(redirect_pc, 32'h0000_5000);
    chk({link_we, link_reg_field, link_data}, {1'b1, 5'h07, 32'h0000_0308});
    // One minor bit off: must not decode while still presented as valid
    issue(enc(1'b0, 5'h01, 5'h02) ^ 32'h0000_0040, 32'h0000_0400, 32'h0000_6001, 1'b1);
    chk({redirect, is_jump}, 32'h0000_0000);
    @(posedge core_clk);
    #1;
    instr_valid = 1'b0;
    chk({redirect, link_we}, 32'h0000_0000);
  endtask : t_regjump

  task automatic t_barrier();
    issue(enc(1'b1, 5'h00, 5'h08), 32'h0000_0500, 32'h0000_7001, 1'b1);
    chk({link_we, stall, hazard_clear_req, redirect, is_barrier}, 32'h0000_000d);
    target_value = 32'hffff_ffff;
    repeat (3) @(posedge core_clk);
    #1;
    // Decode held the jump through the wait; it must not be taken a second time
    chk({stall, redirect, link_we}, 32'h0000_0004);
    instr_valid       = 1'b0;
    hazard_clear_done = 1'b1;
    @(posedge core_clk);
    #1;
    hazard_clear_done = 1'b0;
    chk({redirect, squash_next, hazard_clear_req}, 32'h0000_0006);
    chk(redirect_pc, 32'h0000_7000);
  endtask : t_barrier

  task automatic stop_test();
    if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test

  initial begin
    rst_b             = 1'b0;
    instr_valid       = 1'b0;
    instr_word        = 32'h0000_0000;
    instr_addr        = 32'h0000_0000;
    target_value      = 32'h0000_0000;
    hazard_clear_done = 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    chk({redirect, link_we, instr_set_select_bit}, 32'h0000_0001);
    t_plain();
    t_fault();
    t_regjump();
    t_barrier();
    repeat (2) @(posedge core_clk);
    stop_test();
  end

  // Whole run is under 60 cycles; this limit of 2500 cycles lies far above that
  initial begin
    #20000;
    errors++;
    stop_test();
  end
endmodule : tb_jlr_core
